//--- shared/srah_pkg.sv
// Constants, types and helpers shared by the serial register access host
package srah_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 10;   // System clock period
  localparam int unsigned SCK_PERIOD_MIN_NS = 40;   // Fastest serial clock, 25 MHz
  localparam int unsigned SS_GAP_NS         = 200;  // Least idle time between frames
  // Least times round up to whole cycles
  localparam int unsigned SCK_HALF_CYC = (SCK_PERIOD_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SS_GAP_CYC   = (SS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------------
  // Register map of the host's own command port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;  // Launch, direction, byte offset, busy
  localparam logic [7:0] REG_CFG  = 8'h04;  // Command form and strap level
  localparam logic [7:0] REG_ADDR = 8'h08;  // Register address byte
  localparam logic [7:0] REG_LEN  = 8'h0c;  // Number of data bytes
  localparam logic [7:0] REG_STAT = 8'h10;  // Sticky done / refused flags
  localparam logic [7:0] REG_DATA = 8'h20;  // First data byte slot, one per word

  localparam int unsigned CTRL_GO_BIT      = 0;  // Write 1 to launch a frame
  localparam int unsigned CTRL_WR_BIT      = 1;  // 1 = write transfer
  localparam int unsigned CTRL_OFF_LSB     = 2;  // Three-bit byte offset
  localparam int unsigned CTRL_BUSY_BIT    = 0;  // Read: frame in progress
  localparam int unsigned CFG_FAST_BIT     = 0;  // 1 = fast command form
  localparam int unsigned CFG_STRAP_BIT    = 1;  // Level driven on the select strap
  localparam int unsigned STAT_DONE_BIT    = 0;  // Frame finished
  localparam int unsigned STAT_REFUSED_BIT = 1;  // Launch refused
  localparam logic        STRAP_RESET      = 1'b1;  // Serial interface chosen by default
  localparam logic        FAST_RESET       = 1'b0;  // Normal form by default

  // ---------------------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CMD_NORMAL_TOP  = 3'h3;  // Upper bits of a normal command
  localparam logic [2:0] CMD_SELECT_CODE = 3'h0;  // Single-chip device select code
  localparam int unsigned CMD_FORM_BIT   = 4;     // 0 normal, 1 fast

  // ---------------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_TRAIL, ST_GAP} srah_st_t;
  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} srah_ph_t;

  // Builds a command byte in either form, select code always zero
  function automatic logic [7:0] make_cmd(input logic fast, input logic [2:0] off, input logic wr);
    logic [7:0] c;
    c = fast ? {off, 1'b1, CMD_SELECT_CODE, wr} : {CMD_NORMAL_TOP, 1'b0, CMD_SELECT_CODE, wr};
    return c;
  endfunction : make_cmd

endpackage : srah_pkg

//--- shared/srah_byte_if.sv
// Byte handshake between the frame sequencer and the bit shifter
`timescale 1ns/1ps
interface srah_byte_if;
  logic       ce;       // Clock enable, freezes the shifter
  logic       start;    // One-cycle pulse, shift tx_byte
  logic [7:0] tx_byte;  // Byte to send, MSB first
  logic       miso_s;   // Synchronised slave output
  logic       done;     // One-cycle pulse, byte finished
  logic [7:0] rx_byte;  // Byte received, valid with done
  logic       sck;      // Serial clock flop
  logic       mosi;     // Serial data flop

  modport ctl (output ce, start, tx_byte, miso_s, input done, rx_byte, sck, mosi);
  modport eng (input ce, start, tx_byte, miso_s, output done, rx_byte, sck, mosi);
endinterface : srah_byte_if

//--- logic/srah_shift_eng.sv
// Bit shifter: one byte per start, mode 3 timing on the serial clock
`timescale 1ns/1ps
module srah_shift_eng #(
  parameter int unsigned HALF = srah_pkg::SCK_HALF_CYC  // Cycles per clock half
) (
  input wire logic sys_clk_i,  // System clock
  input wire logic rst_b_i,    // Async reset, active low
  srah_byte_if.eng bi          // Byte handshake
);

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  if (HALF < srah_pkg::SCK_HALF_CYC || HALF > 15) begin : g_chk
    $error("HALF out of range for 25 MHz limit or counter width");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    srah_pkg::srah_ph_t ph;    // Clock phase
    logic [3:0]         cnt;   // Cycles within phase
    logic [2:0]         bitn;  // Bit index
    logic [7:0]         sh;    // Shift register, tx out / rx in
    logic               sck;   // Serial clock
    logic               mosi;  // Serial data out
    logic               done;  // Byte finished pulse
  } srah_eng_t;

  srah_eng_t r;    // Current state
  srah_eng_t nxt;  // Next state

  // Phase sequencing, data moves on falling edges only
  always_comb begin
    nxt      = r;
    nxt.done = 1'b0;
    unique case (r.ph)
      srah_pkg::PH_IDLE: begin
        // Clock rests high between bytes
        if (bi.start) begin
          nxt.sh   = bi.tx_byte;
          nxt.mosi = bi.tx_byte[7];  // MSB first
          nxt.sck  = 1'b0;           // Falling edge drives data
          nxt.cnt  = '0;
          nxt.bitn = '0;
          nxt.ph   = srah_pkg::PH_LOW;
        end
      end
      srah_pkg::PH_LOW: begin
        if (r.cnt == 4'(HALF - 1)) begin
          nxt.sck = 1'b1;  // Rising edge, slave samples mosi
          nxt.cnt = '0;
          nxt.ph  = srah_pkg::PH_HIGH;
        end else begin
          nxt.cnt = r.cnt + 4'h1;
        end
      end
      srah_pkg::PH_HIGH: begin
        if (r.cnt == 4'(HALF - 1)) begin
          // Synchroniser lag equals the high phase, so this is the rising-edge value
          nxt.sh  = {r.sh[6:0], bi.miso_s};
          nxt.cnt = '0;
          if (r.bitn == 3'h7) begin
            nxt.done = 1'b1;  // Clock stays parked high
            nxt.ph   = srah_pkg::PH_IDLE;
          end else begin
            nxt.bitn = r.bitn + 3'h1;
            nxt.sck  = 1'b0;
            nxt.mosi = r.sh[6];  // Next bit on falling edge
            nxt.ph   = srah_pkg::PH_LOW;
          end
        end else begin
          nxt.cnt = r.cnt + 4'h1;
        end
      end
      default: nxt.ph = srah_pkg::PH_IDLE;  // Unused encoding
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r     <= '0;
      r.sck <= 1'b1;  // Idle high from reset
    end else if (bi.ce) begin
      r <= nxt;
    end
  end

  assign bi.done    = r.done;
  assign bi.rx_byte = r.sh;
  assign bi.sck     = r.sck;
  assign bi.mosi    = r.mosi;

endmodule : srah_shift_eng

//--- logic/srah_host.sv
// Host controller that frames register accesses to a paged serial slave
// Function
// - Select falls only while clock high
// - Keep idle gap between frames
// - Clock no faster than the limit
// - Clock polarity one, rests high
// - Drive on falling, sample on rising
// - Clock toggles only inside a frame
// - Command, page, address go on mosi
// - Bytes are command, address, then data
// - Use one command form only; here the config register can switch form between frames
// - Normal form carries fixed upper pattern
// - Device select code is zero
// - Page set first, then base address
// - One frame per distinct register
// - Frame ends when select rises
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module srah_host #(
  parameter int unsigned DEPTH = 8,                       // Data bytes per frame
  parameter int unsigned HALF  = srah_pkg::SCK_HALF_CYC,  // Cycles per clock half
  parameter int unsigned GAP   = srah_pkg::SS_GAP_CYC     // Idle cycles between frames
) (
  input  wire logic        sys_clk_i,                 // System clock, 100 MHz
  input  wire logic        rst_b_i,                   // Async reset, active low
  input  wire logic        ce_i,                      // Clock enable, freezes state
  input  wire logic [7:0]  reg_addr_i,                // Command port address
  input  wire logic [31:0] reg_wdata_i,               // Command port write data
  input  wire logic        reg_wr_i,                  // Write strobe
  input  wire logic        reg_rd_i,                  // Read strobe
  output logic      [31:0] reg_rdata_o,               // Read data, cycle after strobe
  output logic             spi_ss_n_o,                // Slave select, active low
  output logic             spi_sck_o,                 // Serial clock
  output logic             spi_mosi_o,                // Master data out
  input  wire logic        spi_miso_i,                // Slave data in, asynchronous
  output logic             interface_select_strap_o   // Strap level to the slave
);

  // ---------------------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------------------
  if (DEPTH < 2 || DEPTH > 8) begin : g_chk_depth
    $error("DEPTH must lie in 2..8");
  end
  if (GAP < srah_pkg::SS_GAP_CYC || GAP > 255) begin : g_chk_gap
    $error("GAP below idle minimum or above counter width");
  end

  localparam int unsigned IW = $clog2(DEPTH);  // Buffer index width

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    srah_pkg::srah_st_t     st;       // Frame state
    logic [7:0]             cnt;      // Lead, trail and gap counter
    logic [3:0]             idx;      // Byte index in frame
    logic                   issued;   // Byte handed to shifter
    logic [7:0]             cmd;      // Latched command byte
    logic [7:0]             addr;     // Register address byte
    logic [3:0]             len;      // Data byte count
    logic                   fast;     // Fast command form
    logic                   strap;    // Strap level
    logic                   done;     // Sticky frame done
    logic                   refused;  // Sticky launch refused
    logic [DEPTH-1:0][7:0]  buf_q;    // Data bytes
    logic                   ss_n;     // Select output
    logic [31:0]            rdata;    // Read data output
    logic                   s1;       // Miso first sync flop
    logic                   s2;       // Miso second sync flop
    logic                   start;    // Byte start pulse
    logic [7:0]             tx;       // Byte for shifter
  } srah_host_t;

  srah_host_t  r;    // Current state
  srah_host_t  nxt;  // Next state
  srah_byte_if bi ();  // Link to the shifter

  // Decodes a data slot address
  function automatic logic data_hit(input logic [7:0] a);
    logic [7:0] off;
    off = a - srah_pkg::REG_DATA;
    return (a >= srah_pkg::REG_DATA) && (off[1:0] == 2'h0) && (off[7:2] < 6'(DEPTH));
  endfunction : data_hit

  // Slot index from a data address
  function automatic logic [IW-1:0] data_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - srah_pkg::REG_DATA;
    return off[IW+1:2];
  endfunction : data_idx

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt       = r;
    nxt.start = 1'b0;
    nxt.rdata = '0;  // Read data stand for one cycle only
    // Two flops before any logic looks at the slave output
    nxt.s1 = spi_miso_i;
    nxt.s2 = r.s1;

    // Register writes, configuration only while idle
    if (reg_wr_i) begin
      if (reg_addr_i == srah_pkg::REG_STAT) begin
        // Write one to clear; events below override
        if (reg_wdata_i[srah_pkg::STAT_DONE_BIT])    nxt.done    = 1'b0;
        if (reg_wdata_i[srah_pkg::STAT_REFUSED_BIT]) nxt.refused = 1'b0;
      end else if (r.st == srah_pkg::ST_IDLE) begin
        if (reg_addr_i == srah_pkg::REG_CFG) begin
          // One form per frame, changeable between frames
          nxt.fast  = reg_wdata_i[srah_pkg::CFG_FAST_BIT];
          nxt.strap = reg_wdata_i[srah_pkg::CFG_STRAP_BIT];
        end else if (reg_addr_i == srah_pkg::REG_ADDR) begin
          nxt.addr = reg_wdata_i[7:0];  // Page or base address
        end else if (reg_addr_i == srah_pkg::REG_LEN) begin
          nxt.len = (reg_wdata_i[7:0] > 8'(DEPTH)) ? 4'(DEPTH) : reg_wdata_i[3:0];
        end else if (data_hit(reg_addr_i)) begin
          nxt.buf_q[data_idx(reg_addr_i)] = reg_wdata_i[7:0];
        end else if (reg_addr_i == srah_pkg::REG_CTRL && reg_wdata_i[srah_pkg::CTRL_GO_BIT]) begin
          if (r.fast && reg_wdata_i[srah_pkg::CTRL_WR_BIT]) begin
            nxt.refused = 1'b1;  // Fast form has no write
          end else begin
            // Direction in bit zero, zero select code
            nxt.cmd = srah_pkg::make_cmd(r.fast,
                        reg_wdata_i[srah_pkg::CTRL_OFF_LSB +: 3], reg_wdata_i[srah_pkg::CTRL_WR_BIT]);
            nxt.ss_n = 1'b0;  // Clock is parked high here
            nxt.cnt  = '0;
            nxt.idx  = '0;
            nxt.st   = srah_pkg::ST_LEAD;
          end
        end
      end
    end

    // Register reads, answered the next cycle
    if (reg_rd_i) begin
      if (reg_addr_i == srah_pkg::REG_CTRL) begin
        nxt.rdata[srah_pkg::CTRL_BUSY_BIT] = (r.st != srah_pkg::ST_IDLE);
      end else if (reg_addr_i == srah_pkg::REG_CFG) begin
        nxt.rdata[srah_pkg::CFG_FAST_BIT]  = r.fast;
        nxt.rdata[srah_pkg::CFG_STRAP_BIT] = r.strap;
      end else if (reg_addr_i == srah_pkg::REG_ADDR) begin
        nxt.rdata[7:0] = r.addr;
      end else if (reg_addr_i == srah_pkg::REG_LEN) begin
        nxt.rdata[3:0] = r.len;
      end else if (reg_addr_i == srah_pkg::REG_STAT) begin
        nxt.rdata[srah_pkg::STAT_DONE_BIT]    = r.done;
        nxt.rdata[srah_pkg::STAT_REFUSED_BIT] = r.refused;
      end else if (data_hit(reg_addr_i)) begin
        nxt.rdata[7:0] = r.buf_q[data_idx(reg_addr_i)];
      end
    end

    // Frame sequencer
    unique case (r.st)
      srah_pkg::ST_IDLE: begin
        // Waiting for a launch
      end
      srah_pkg::ST_LEAD: begin
        // Select low with the clock still high for a half period
        if (r.cnt == 8'(HALF - 1)) begin
          nxt.cnt    = '0;
          nxt.issued = 1'b0;
          nxt.st     = srah_pkg::ST_XFER;
        end else begin
          nxt.cnt = r.cnt + 8'h1;
        end
      end
      srah_pkg::ST_XFER: begin
        if (!r.issued) begin
          // Command, then address, then data, all on mosi
          nxt.start  = 1'b1;
          nxt.issued = 1'b1;
          if (r.idx == 4'h0) begin
            nxt.tx = r.cmd;
          end else if (r.idx == 4'h1) begin
            nxt.tx = r.addr;  // One register address per frame
          end else begin
            // Reads send zeros; data bytes follow the address with no dummy byte
            nxt.tx = r.cmd[0] ? r.buf_q[IW'(r.idx - 4'h2)] : 8'h00;
          end
        end else if (bi.done) begin
          nxt.issued = 1'b0;
          if (r.idx >= 4'h2 && !r.cmd[0]) begin
            // Slave advances its own address, so slot follows byte order
            nxt.buf_q[IW'(r.idx - 4'h2)] = bi.rx_byte;
          end
          if (r.idx == r.len + 4'h1) begin
            nxt.cnt = '0;
            nxt.st  = srah_pkg::ST_TRAIL;
          end else begin
            nxt.idx = r.idx + 4'h1;
          end
        end
      end
      srah_pkg::ST_TRAIL: begin
        // Clock high again for a half period before select rises
        if (r.cnt == 8'(HALF - 1)) begin
          nxt.ss_n = 1'b1;  // Frame closes only here
          nxt.done = 1'b1;  // Set wins over a same-cycle clear
          nxt.cnt  = '0;
          nxt.st   = srah_pkg::ST_GAP;
        end else begin
          nxt.cnt = r.cnt + 8'h1;
        end
      end
      srah_pkg::ST_GAP: begin
        // Idle time before the next launch is accepted
        if (r.cnt == 8'(GAP - 1)) begin
          nxt.st = srah_pkg::ST_IDLE;
        end else begin
          nxt.cnt = r.cnt + 8'h1;
        end
      end
      default: nxt.st = srah_pkg::ST_IDLE;  // Unused encoding
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r       <= '0;
      r.ss_n  <= 1'b1;
      r.strap <= srah_pkg::STRAP_RESET;  // Serial port by default
      r.fast  <= srah_pkg::FAST_RESET;
    end else if (ce_i) begin
      r <= nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Shifter and outputs
  // ---------------------------------------------------------------------------
  assign bi.ce      = ce_i;
  assign bi.start   = r.start;
  assign bi.tx_byte = r.tx;
  assign bi.miso_s  = r.s2;

  // Host alone makes select and clock
  srah_shift_eng #(.HALF(HALF)) u_eng (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .bi        (bi)
  );

  assign reg_rdata_o              = r.rdata;
  assign spi_ss_n_o               = r.ss_n;
  assign spi_sck_o                = bi.sck;
  assign spi_mosi_o               = bi.mosi;
  assign interface_select_strap_o = r.strap;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  localparam int GAP_MIN = 20;  // Idle cycles at 100 MHz

  logic [7:0] gap_cnt;   // Cycles since select rose, saturating
  logic [3:0] byte_cnt;  // Bytes shifted in the current frame
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_cnt  <= 8'hff;
      byte_cnt <= '0;
    end else begin
      gap_cnt  <= !spi_ss_n_o ? 8'h00 : (gap_cnt == 8'hff ? gap_cnt : gap_cnt + 8'h1);
      byte_cnt <= spi_ss_n_o ? 4'h0 : (bi.done && ce_i ? byte_cnt + 4'h1 : byte_cnt);
    end
  end

  property p_ss_fall_high;
    $fell(spi_ss_n_o) |-> spi_sck_o;
  endproperty
  a_ss_fall_high: assert property (p_ss_fall_high) else $error("select fell with clock low");

  property p_gap;
    $fell(spi_ss_n_o) |-> $past(gap_cnt) >= GAP_MIN;
  endproperty
  a_gap: assert property (p_gap) else $error("idle gap between frames too short");

  property p_low_min;
    $fell(spi_sck_o) |=> !spi_sck_o;
  endproperty
  a_low_min: assert property (p_low_min) else $error("clock low phase too short");

  property p_high_min;
    $rose(spi_sck_o) |=> spi_sck_o;
  endproperty
  a_high_min: assert property (p_high_min) else $error("clock high phase too short");

  property p_idle_high;
    spi_ss_n_o |-> spi_sck_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock not parked high outside frame");

  property p_mosi_edge;
    $changed(spi_mosi_o) |-> $fell(spi_sck_o);
  endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("mosi changed away from falling edge");

  property p_cmd_code;
    (r.start && r.idx == 4'h0) |-> (r.tx[3:1] == 3'h0)
      && (r.tx[4] || r.tx[7:5] == 3'h3) && (r.tx == srah_pkg::make_cmd(r.fast, r.tx[7:5], r.tx[0]));
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad command byte issued");

  property p_ss_rise;
    $rose(spi_ss_n_o) |-> spi_sck_o && $past(spi_sck_o) && $past(byte_cnt) == $past(r.len) + 4'h2;
  endproperty
  a_ss_rise: assert property (p_ss_rise) else $error("frame closed with wrong byte count");

  property p_fast_wr;
    (ce_i && reg_wr_i && reg_addr_i == srah_pkg::REG_CTRL && reg_wdata_i[0] && reg_wdata_i[1]
      && r.fast && r.st == srah_pkg::ST_IDLE) |=> r.refused && spi_ss_n_o;
  endproperty
  a_fast_wr: assert property (p_fast_wr) else $error("fast write not refused");

  c_read:    cover property ($rose(spi_ss_n_o) && !r.cmd[0]);
  c_write:   cover property ($rose(spi_ss_n_o) && r.cmd[0]);
  c_fast:    cover property ($rose(spi_ss_n_o) && r.cmd[4]);
  c_refused: cover property ($rose(r.refused));

endmodule : srah_host

//--- verif/srah_slave_model.sv
// Behavioural serial slave that answers the host on the far side of the link
`timescale 1ns/1ps
module srah_slave_model (
  input  wire logic ss_n_i,  // Select, active low
  input  wire logic sck_i,   // Serial clock from host
  input  wire logic mosi_i,  // Data from host
  output logic      miso_o   // Data to host
);
  logic [7:0] rx [0:15];  // Bytes of the last frame
  logic [7:0] sh;         // Receive shifter
  logic [7:0] tx;         // Send shifter
  int         nbit;       // Bits this frame
  int         nbyte;      // Bytes this frame
  int         nframe;     // Frames closed
  initial begin
    miso_o = 1'b1;
    nframe = 0;
  end
  // Frame opens, byte count restarts
  always @(negedge ss_n_i) begin
    nbit = 0;
    nbyte = 0;
  end
  // Data bytes of a read come from base plus offset, one step per byte
  always @(negedge sck_i) begin
    if (!ss_n_i) begin
      if (nbit % 8 == 0) begin
        // A wrong select code leaves the data bytes at zero
        if (nbyte >= 2 && !rx[0][0] && rx[0][3:1] == 3'h0)
          tx = 8'ha0 + 8'(nbyte - 2) + (rx[0][4] ? 8'(rx[0][7:5]) : 8'h00);
        else
          tx = 8'h00;
      end
      miso_o = tx[7];
      tx = {tx[6:0], 1'b0};
    end
  end
  // Sample on rising edge; first byte command, second address
  always @(posedge sck_i) begin
    if (!ss_n_i) begin
      sh = {sh[6:0], mosi_i};
      nbit++;
      if (nbit % 8 == 0) begin
        rx[nbyte] = sh;
        nbyte++;
      end
    end
  end
  // Released line shows the inverse so a stale value never passes
  always @(posedge ss_n_i) begin
    miso_o = ~miso_o;
    nframe++;
  end
endmodule : srah_slave_model

//--- verif/srah_host_tb.sv
// Self-checking bench for the serial register access host
`timescale 1ns/1ps
module srah_host_tb;
  logic        sys_clk_i, rst_b_i, reg_wr_i, reg_rd_i, spi_miso_i;  // Drives
  logic [7:0]  reg_addr_i;                                            // Port address
  logic [31:0] reg_wdata_i, reg_rdata_o, d;                           // Port data
  logic        spi_ss_n_o, spi_sck_o, spi_mosi_o, interface_select_strap_o;  // Link
  int          error_cnt = 0;
  int          total_checks = 0;
  srah_host u_srah_host (.sys_clk_i, .rst_b_i, .ce_i(1'b1), .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .spi_ss_n_o, .spi_sck_o, .spi_mosi_o, .spi_miso_i, .interface_select_strap_o);
  srah_slave_model u_srah_slave_model (.ss_n_i(spi_ss_n_o), .sck_i(spi_sck_o), .mosi_i(spi_mosi_o),
    .miso_o(spi_miso_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  // Launch, wait for busy to drop under a bound, then clear the flags
  task automatic run(input logic [31:0] ctrl);
    wr(srah_pkg::REG_CTRL, ctrl);
    rd(srah_pkg::REG_CTRL, d);
    chk(d & 32'h1, 32'h1);
    for (int n = 0; n < 400 && d[0] !== 1'b0; n++) rd(srah_pkg::REG_CTRL, d);
    chk(d & 32'h1, 32'h0);
    rd(srah_pkg::REG_STAT, d);
    chk(d, 32'h1);
    wr(srah_pkg::REG_STAT, 32'h3);
  endtask : run
  task automatic t_reset;
    rd(srah_pkg::REG_CFG, d);
    chk(d, 32'h2);
    chk(32'({spi_ss_n_o, spi_sck_o, interface_select_strap_o}), 32'h7);
    rd(8'h40, d);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_nwrite;
    wr(srah_pkg::REG_ADDR, 32'hff);
    wr(srah_pkg::REG_LEN, 32'h1);
    wr(srah_pkg::REG_DATA, 32'h10);
    run(32'h3);
    chk(32'(u_srah_slave_model.rx[0]), 32'h61);
    chk(32'(u_srah_slave_model.rx[1]), 32'hff);
    chk(32'(u_srah_slave_model.rx[2]), 32'h10);
    chk(32'(u_srah_slave_model.nbyte), 32'h3);
  endtask : t_nwrite
  task automatic t_nread;
    wr(srah_pkg::REG_ADDR, 32'hf0);
    wr(srah_pkg::REG_LEN, 32'h2);
    run(32'h1);
    chk(32'(u_srah_slave_model.rx[0]), 32'h60);
    chk(32'(u_srah_slave_model.nbit), 32'h20);
    rd(srah_pkg::REG_DATA, d);
    chk(d, 32'ha0);
    rd(srah_pkg::REG_DATA + 8'h04, d);
    chk(d, 32'ha1);
  endtask : t_nread
  task automatic t_fast;
    wr(srah_pkg::REG_CFG, 32'h3);
    wr(srah_pkg::REG_LEN, 32'h1);
    run(32'h0d);
    chk(32'(u_srah_slave_model.rx[0]), 32'h70);
    rd(srah_pkg::REG_DATA, d);
    chk(d, 32'ha3);
  endtask : t_fast
  // Fast write must be refused with no frame; then strap follows config
  task automatic t_refuse;
    int f;
    f = u_srah_slave_model.nframe;
    wr(srah_pkg::REG_CTRL, 32'h3);
    rd(srah_pkg::REG_STAT, d);
    chk(d, 32'h2);
    chk(32'(u_srah_slave_model.nframe), 32'(f));
    wr(srah_pkg::REG_STAT, 32'h3);
    wr(srah_pkg::REG_CFG, 32'h0);
    rd(srah_pkg::REG_CFG, d);
    chk(32'(interface_select_strap_o), 32'h0);
  endtask : t_refuse
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_nwrite();
    t_nread();
    t_fast();
    t_refuse();
    results();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #300us;
    error_cnt++;
    results();
  end
endmodule : srah_host_tb
